// *** fwpl_far_model.sv ***
// far-side model: host-driven control pins and a busy memory engine
`timescale 1ns/1ps
module fwpl_far_model #(
  parameter int BUSY_CYC = 3
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic wp_lvl,
  input  wire logic hold_lvl,
  input  wire logic pin2_o,
  input  wire logic pin2_oe,
  input  wire logic pin3_o,
  input  wire logic pin3_oe,
  input  wire logic op_valid,
  output logic      pin2,
  output logic      pin3,
  output logic      busy
);
  int cnt;
  // ------------
  // pin wires: the device wins while it drives
  // ------------
  // host drives the control pins, never ties them to the rail
  assign pin2 = pin2_oe ? pin2_o : wp_lvl;
  assign pin3 = pin3_oe ? pin3_o : hold_lvl;
  // ------------
  // engine busy for a fixed span after each grant
  // ------------
  assign busy = (cnt != 0);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt <= 0;
    else if (op_valid)
      cnt <= BUSY_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
endmodule

// *** fwpl_pkg.sv ***
// constants and types for the flash write-protect logic
package fwpl_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_WDATA  = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_PINS   = 8'h14;

  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_VOL_ENABLE    = 8'h50;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_PROG          = 8'h02;
  localparam logic [7:0] OP_PROG_QUAD_A   = 8'h32;
  localparam logic [7:0] OP_PROG_QUAD_B   = 8'h38;
  localparam logic [7:0] OP_ERASE_4K_A    = 8'hD7;
  localparam logic [7:0] OP_ERASE_4K_B    = 8'h20;
  localparam logic [7:0] OP_ERASE_32K     = 8'h52;
  localparam logic [7:0] OP_ERASE_64K     = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'h60;

  // ----------------------------------------------------------------
  // status and result field positions, reset values
  // ----------------------------------------------------------------
  localparam int SB_BUSY  = 0;
  localparam int SB_LATCH = 1;
  localparam int SB_BP_LO = 2;
  localparam int SB_QUAD  = 6;
  localparam int SB_SWD   = 7;
  localparam logic [5:0] SR_PROT_RST = 6'h00;
  localparam logic [7:0] WDATA_RST   = 8'h00;
  localparam logic [23:0] ADDR_RST   = 24'h00_0000;

  localparam int RB_ACCEPT  = 0;
  localparam int RB_NO_LATCH = 1;
  localparam int RB_PROT    = 2;
  localparam int RB_LOCKED  = 3;
  localparam int RB_BUSY    = 4;
  localparam int RB_UNKNOWN = 5;
  localparam int RB_OPC_LO  = 8;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int BLK_LSB = 16;
  localparam logic [2:0] BLKMSK_4M   = 3'h7;
  localparam logic [2:0] BLKMSK_2M   = 3'h3;
  localparam logic [2:0] BLKMSK_1M   = 3'h1;
  localparam logic [2:0] BLKMSK_512K = 3'h0;

  typedef enum logic [1:0] {
    DENS_4M   = 2'b00,
    DENS_2M   = 2'b01,
    DENS_1M   = 2'b10,
    DENS_512K = 2'b11
  } fwpl_density_e;

  typedef enum logic [2:0] {
    OPK_PROG   = 3'b000,
    OPK_ER4K   = 3'b001,
    OPK_ER32K  = 3'b010,
    OPK_ER64K  = 3'b011,
    OPK_CHIP   = 3'b100
  } fwpl_opkind_e;

endpackage

// *** fwpl_top.sv ***
// flash write-protect logic: status bits, protect map, pin roles, bus
`timescale 1ns/1ps

module fwpl_top #(
  parameter fwpl_pkg::fwpl_density_e DENSITY  = fwpl_pkg::DENS_4M,
  parameter bit                      ALT_MAP  = 1'b0,
  parameter bit                      OPTION_C = 1'b0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        data_line_2_i,
  output logic             data_line_2_o,
  output logic             data_line_2_oe,
  input  wire logic        data_line_3_i,
  output logic             data_line_3_o,
  output logic             data_line_3_oe,
  input  wire logic        quad_d2_o,
  input  wire logic        quad_d2_oe,
  input  wire logic        quad_d3_o,
  input  wire logic        quad_d3_oe,
  output logic             quad_d2_i,
  output logic             quad_d3_i,
  output logic             quad_enable,
  output logic             hold_active,
  input  wire logic        mem_busy,
  output logic             mem_op_valid,
  output logic      [2:0]  mem_op_kind,
  output logic      [23:0] mem_op_addr
);

  // ----------------------------------------------------------------
  // protect map
  // ----------------------------------------------------------------
  function automatic logic [7:0] prot_mask(input logic [3:0] bp);
    logic [7:0] m;
    m = 8'h00;
    unique case (DENSITY)
      fwpl_pkg::DENS_4M:
        unique case (bp)
          4'h0: m = 8'h00;
          4'h1: m = 8'h80;
          4'h2: m = 8'hC0;
          4'h3: m = 8'hF0;
          4'h4: m = 8'hFC;
          4'h5: m = 8'hFE;
          4'h9: m = ALT_MAP ? 8'hFF : 8'h01;
          4'hA: m = ALT_MAP ? 8'h7F : 8'h03;
          4'hB: m = ALT_MAP ? 8'h3F : 8'h0F;
          4'hC: m = ALT_MAP ? 8'h0F : 8'h3F;
          4'hD: m = ALT_MAP ? 8'h03 : 8'h7F;
          4'hE: m = ALT_MAP ? 8'h01 : 8'hFF;
          4'hF: m = ALT_MAP ? 8'h00 : 8'hFF;
          default: m = 8'hFF;
        endcase
      fwpl_pkg::DENS_2M:
        unique case (bp)
          4'h0: m = 8'h00;
          4'h1: m = 8'h08;
          4'h2: m = 8'h0C;
          4'h3: m = 8'h0E;
          4'h9: m = ALT_MAP ? 8'h0F : 8'h01;
          4'hA: m = ALT_MAP ? 8'h0F : 8'h03;
          4'hB: m = ALT_MAP ? 8'h0F : 8'h07;
          4'hC: m = ALT_MAP ? 8'h07 : 8'h0F;
          4'hD: m = ALT_MAP ? 8'h03 : 8'h0F;
          4'hE: m = ALT_MAP ? 8'h01 : 8'h0F;
          4'hF: m = ALT_MAP ? 8'h00 : 8'h0F;
          default: m = 8'h0F;
        endcase
      fwpl_pkg::DENS_1M:
        unique case (bp)
          4'h0: m = 8'h00;
          4'h1: m = 8'h02;
          4'h9: m = ALT_MAP ? 8'h03 : 8'h01;
          4'hE: m = ALT_MAP ? 8'h01 : 8'h03;
          4'hF: m = ALT_MAP ? 8'h00 : 8'h03;
          default: m = 8'h03;
        endcase
      fwpl_pkg::DENS_512K:
        unique case (bp)
          4'h0: m = 8'h00;
          4'hF: m = ALT_MAP ? 8'h00 : 8'h01;
          default: m = 8'h01;
        endcase
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        dph_wr_r;
  logic [7:0]  dph_ofs_r;
  logic [31:0] hrdata_r;
  logic [23:0] addr_r;
  logic [7:0]  wdata_r;
  logic        latch_r;
  logic        vol_en_r;
  logic [5:0]  nv_sr_r;
  logic [5:0]  vol_sr_r;
  logic [15:0] result_r;
  logic        op_valid_r;
  logic [2:0]  op_kind_r;
  logic [23:0] op_addr_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       addr_take = hsel & hready & htrans[1];
  wire       map_hit   = (haddr[31:5] == 27'h000_0000);
  wire [7:0] a_ofs     = haddr[7:0];
  wire       wr_cmd    = dph_wr_r & (dph_ofs_r == fwpl_pkg::OFS_CMD);
  wire       wr_addr   = dph_wr_r & (dph_ofs_r == fwpl_pkg::OFS_ADDR);
  wire       wr_wdata  = dph_wr_r & (dph_ofs_r == fwpl_pkg::OFS_WDATA);

  // ----------------------------------------------------------------
  // pin roles
  // ----------------------------------------------------------------
  wire quad_on = vol_sr_r[fwpl_pkg::SB_QUAD - fwpl_pkg::SB_BP_LO];
  wire swd = vol_sr_r[fwpl_pkg::SB_SWD - fwpl_pkg::SB_BP_LO];
  wire [3:0] bp = vol_sr_r[3:0];

  // quad bit hands the control pins to the data path
  assign data_line_2_o  = quad_on & quad_d2_o;
  assign data_line_2_oe = quad_on & quad_d2_oe;
  assign data_line_3_o  = quad_on & quad_d3_o;
  assign data_line_3_oe = quad_on & quad_d3_oe;
  assign quad_d2_i      = data_line_2_i;
  assign quad_d3_i      = data_line_3_i;
  assign quad_enable    = quad_on;
  // hold only acts while the pin is a control pin
  assign hold_active    = ~quad_on & ~data_line_3_i;

  // pin acts as protect only while quad is off
  wire hw_lock = swd & ~quad_on & ~data_line_2_i;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire [7:0] opc = hwdata[7:0];
  wire is_wr_en = (opc == fwpl_pkg::OP_WRITE_ENABLE);
  wire is_wrdi  = (opc == fwpl_pkg::OP_WRITE_DISABLE);
  wire is_vwren = (opc == fwpl_pkg::OP_VOL_ENABLE);
  wire is_wrst  = (opc == fwpl_pkg::OP_WRITE_STATUS);
  wire is_prog  = (opc == fwpl_pkg::OP_PROG)
                | (opc == fwpl_pkg::OP_PROG_QUAD_A)
                | (opc == fwpl_pkg::OP_PROG_QUAD_B);
  wire is_er4   = (opc == fwpl_pkg::OP_ERASE_4K_A)
                | (opc == fwpl_pkg::OP_ERASE_4K_B);
  wire is_er32  = (opc == fwpl_pkg::OP_ERASE_32K);
  wire is_er64  = (opc == fwpl_pkg::OP_ERASE_64K);
  wire is_chip  = (opc == fwpl_pkg::OP_CHIP_ERASE_A)
                | (opc == fwpl_pkg::OP_CHIP_ERASE_B);
  wire is_mem   = is_prog | is_er4 | is_er32 | is_er64 | is_chip;
  wire known    = is_wr_en | is_wrdi | is_vwren | is_wrst | is_mem;

  // no 64 KB erase on option C or the one-block parts
  wire no_64k = OPTION_C | (DENSITY == fwpl_pkg::DENS_512K);

  wire [2:0] kind_sel =
    is_chip ? fwpl_pkg::OPK_CHIP :
    is_er64 ? (no_64k ? fwpl_pkg::OPK_ER32K : fwpl_pkg::OPK_ER64K) :
    is_er32 ? fwpl_pkg::OPK_ER32K :
    is_er4  ? fwpl_pkg::OPK_ER4K : fwpl_pkg::OPK_PROG;

  // ----------------------------------------------------------------
  // protection check
  // ----------------------------------------------------------------
  wire [2:0] blk_msk =
    (DENSITY == fwpl_pkg::DENS_4M) ? fwpl_pkg::BLKMSK_4M :
    (DENSITY == fwpl_pkg::DENS_2M) ? fwpl_pkg::BLKMSK_2M :
    (DENSITY == fwpl_pkg::DENS_1M) ? fwpl_pkg::BLKMSK_1M :
    fwpl_pkg::BLKMSK_512K;
  wire [7:0] pmask = prot_mask(bp);
  // addresses past the array wrap onto it, as the array decode does
  wire [2:0] blk = addr_r[fwpl_pkg::BLK_LSB +: 3] & blk_msk;
  // every erase size but chip erase stays inside one 64 KB block; chip erase checks all blocks
  wire tgt_prot = is_chip ? (|pmask) : pmask[blk];

  // volatile path skips the latch; memory ops and non-volatile status writes need it
  wire vol_path  = is_wrst & vol_en_r;
  wire need_latch = is_mem | (is_wrst & ~vol_en_r);
  wire rej_busy  = mem_busy;
  wire rej_latch = ~rej_busy & need_latch & ~latch_r;
  // frozen status register ignores the write
  wire rej_lock  = ~rej_busy & is_wrst & hw_lock & (latch_r | vol_en_r);
  wire rej_prot  = ~rej_busy & is_mem & latch_r & tgt_prot;
  wire rej_any   = rej_busy | rej_latch | rej_lock | rej_prot | ~known;
  wire accept    = wr_cmd & known & ~rej_any;
  wire acc_wrst  = accept & is_wrst;
  wire acc_mem   = accept & is_mem;
  wire acc_nvwr  = acc_wrst & ~vol_path;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] status_rd = {vol_sr_r, latch_r, mem_busy};
  wire [31:0] rd_mux =
    ~map_hit                        ? 32'h0000_0000 :
    (a_ofs == fwpl_pkg::OFS_STATUS) ? {24'h00_0000, status_rd} :
    (a_ofs == fwpl_pkg::OFS_ADDR)   ? {8'h00, addr_r} :
    (a_ofs == fwpl_pkg::OFS_WDATA)  ? {24'h00_0000, wdata_r} :
    (a_ofs == fwpl_pkg::OFS_RESULT) ? {16'h0000, result_r} :
    (a_ofs == fwpl_pkg::OFS_PINS)   ?
      {28'h000_0000, vol_en_r, hold_active, quad_on, data_line_2_i} :
    32'h0000_0000;

  wire [15:0] result_nxt = {opc, 2'b00, ~known, rej_busy & known,
                            rej_lock, rej_prot, rej_latch, accept};

  // ----------------------------------------------------------------
  // bus slave: zero wait, always okay
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_r  <= 1'b0;
      dph_ofs_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end
    else if (hready)
    begin
      dph_wr_r  <= addr_take & hwrite & map_hit;
      dph_ofs_r <= a_ofs;
      hrdata_r  <= addr_take ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r  <= fwpl_pkg::ADDR_RST;
      wdata_r <= fwpl_pkg::WDATA_RST;
    end
    else
    begin
      if (wr_addr)
        addr_r <= hwdata[23:0];
      if (wr_wdata)
        wdata_r <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_r  <= 1'b0;
      vol_en_r <= 1'b0;
    end
    else if (wr_cmd)
    begin
      // latch set by enable, dropped by disable or a granted memory or non-volatile status write
      if (accept & is_wr_en)
        latch_r <= 1'b1;
      else if (accept & (is_wrdi | is_mem | acc_nvwr))
        latch_r <= 1'b0;
      // volatile enable only arms the very next command
      vol_en_r <= accept & is_vwren;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // factory value of protect, quad and disable bits
      nv_sr_r  <= fwpl_pkg::SR_PROT_RST;
      vol_sr_r <= fwpl_pkg::SR_PROT_RST;
    end
    else if (acc_wrst)
    begin
      // bits 7..2 only; latch and busy are not loaded from the data
      vol_sr_r <= wdata_r[7:2];
      if (acc_nvwr)
        nv_sr_r <= wdata_r[7:2];
    end
  end

  // ----------------------------------------------------------------
  // grant to the program/erase engine and result
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_valid_r <= 1'b0;
      op_kind_r  <= fwpl_pkg::OPK_PROG;
      op_addr_r  <= fwpl_pkg::ADDR_RST;
      result_r   <= fwpl_pkg::RESULT_RST;
    end
    else
    begin
      // only unprotected targets reach the engine
      op_valid_r <= acc_mem;
      if (acc_mem)
      begin
        op_kind_r <= kind_sel;
        op_addr_r <= addr_r;
      end
      if (wr_cmd)
        result_r <= result_nxt;
    end
  end

  assign mem_op_valid = op_valid_r;
  assign mem_op_kind  = op_kind_r;
  assign mem_op_addr  = op_addr_r;

endmodule

// *** fwpl_top_checker.sv ***
// port assertions for the flash write-protect logic
`timescale 1ns/1ps
module fwpl_top_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        data_line_2_o,
  input wire logic        data_line_2_oe,
  input wire logic        data_line_3_i,
  input wire logic        data_line_3_oe,
  input wire logic        quad_d2_o,
  input wire logic        quad_d2_oe,
  input wire logic        quad_d3_oe,
  input wire logic        quad_enable,
  input wire logic        hold_active,
  input wire logic        mem_op_valid
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ------------
  // pin roles
  // ------------
  property p_d2_oe;
    data_line_2_oe == (quad_enable && quad_d2_oe);
  endproperty
  a_d2_oe: assert property (p_d2_oe)
    else $error("pin2 enable does not follow quad bit");
  property p_d2_o;
    data_line_2_o == (quad_enable && quad_d2_o);
  endproperty
  a_d2_o: assert property (p_d2_o)
    else $error("pin2 value does not follow quad path");
  property p_d3_oe;
    data_line_3_oe == (quad_enable && quad_d3_oe);
  endproperty
  a_d3_oe: assert property (p_d3_oe)
    else $error("pin3 enable does not follow quad bit");
  property p_ctl_pins;
    !quad_enable |-> !data_line_2_oe && !data_line_3_oe;
  endproperty
  a_ctl_pins: assert property (p_ctl_pins)
    else $error("control pin driven with quad off");
  property p_hold;
    hold_active == (!quad_enable && !data_line_3_i);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold flag wrong for pin3 level");
  // ------------
  // grants and status
  // ------------
  property p_pulse;
    mem_op_valid |=> !mem_op_valid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("grant longer than one cycle");
  property p_grant_cause;
    mem_op_valid |-> $past(hsel && hready && htrans[1] && hwrite
      && haddr == {24'h00_0000, fwpl_pkg::OFS_CMD}, 2);
  endproperty
  a_grant_cause: assert property (p_grant_cause)
    else $error("grant without a command write");
  property p_quad_cause;
    $changed(quad_enable) |-> $past(hsel && hready && htrans[1] && hwrite, 2);
  endproperty
  a_quad_cause: assert property (p_quad_cause)
    else $error("quad bit moved without a bus write");
endmodule
bind fwpl_top fwpl_top_checker chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .data_line_2_o(data_line_2_o), .data_line_2_oe(data_line_2_oe),
  .data_line_3_i(data_line_3_i), .data_line_3_oe(data_line_3_oe),
  .quad_d2_o(quad_d2_o), .quad_d2_oe(quad_d2_oe),
  .quad_d3_oe(quad_d3_oe), .quad_enable(quad_enable),
  .hold_active(hold_active), .mem_op_valid(mem_op_valid)
);

// *** fwpl_top_tb.sv ***
// self-checking bench for the flash write-protect logic
`timescale 1ns/1ps
module fwpl_top_tb;
  // ------------
  // signals
  // ------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0]  htrans;
  logic        d2_i, d2_o, d2_oe, d3_i, d3_o, d3_oe, quad_d2_i, quad_d3_i;
  logic        q2_o, q2_oe, q3_o, q3_oe, wp_lvl, hold_lvl, hresp;
  logic [23:0] mem_op_addr;
  logic        quad_enable, hold_active, mem_busy, mem_op_valid;
  logic [2:0]  mem_op_kind;
  int          bad_count, n_tests, n_grant, cycles;
  // protected blocks per code, bit n is block n
  logic [7:0]  pmask [16] = '{8'h00, 8'h80, 8'hC0, 8'hF0, 8'hFC, 8'hFE,
    8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h03, 8'h0F, 8'h3F, 8'h7F, 8'hFF, 8'hFF};
  fwpl_top #(.DENSITY(fwpl_pkg::DENS_4M), .ALT_MAP(1'b0), .OPTION_C(1'b0))
  dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .data_line_2_i(d2_i), .data_line_2_o(d2_o),
    .data_line_2_oe(d2_oe), .data_line_3_i(d3_i), .data_line_3_o(d3_o),
    .data_line_3_oe(d3_oe), .quad_d2_o(q2_o), .quad_d2_oe(q2_oe),
    .quad_d3_o(q3_o), .quad_d3_oe(q3_oe), .quad_d2_i(quad_d2_i),
    .quad_d3_i(quad_d3_i), .quad_enable(quad_enable),
    .hold_active(hold_active), .mem_busy(mem_busy),
    .mem_op_valid(mem_op_valid), .mem_op_kind(mem_op_kind),
    .mem_op_addr(mem_op_addr)
  );
  fwpl_far_model #(.BUSY_CYC(3)) far_u (
    .hclk(hclk), .hresetn(hresetn), .wp_lvl(wp_lvl), .hold_lvl(hold_lvl),
    .pin2_o(d2_o), .pin2_oe(d2_oe), .pin3_o(d3_o), .pin3_oe(d3_oe),
    .op_valid(mem_op_valid), .pin2(d2_i), .pin3(d3_i), .busy(mem_busy)
  );
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // grants are counted here so a missed or extra pulse shows up
  always @(posedge hclk)
  begin
    cycles++;
    if (mem_op_valid === 1'b1)
      n_grant++;
    if (cycles == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  // ------------
  // bus and check helpers
  // ------------
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt();
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wt();
    htrans <= 2'h0;
    hwdata <= wd;
    wt();
    rdata = hrdata;
  endtask
  task automatic cmd(input logic [7:0] op);
    bus(1'b1, fwpl_pkg::OFS_CMD, {24'h00_0000, op});
  endtask
  task automatic res(input logic [5:0] e, input logic [7:0] op);
    bus(1'b0, fwpl_pkg::OFS_RESULT, 32'h0);
    chk("result", {16'h0000, op, 2'h0, e}, rdata);
  endtask
  // latch and busy bits are left out; a granted non-volatile status write clears the latch
  task automatic sr(input logic [7:0] v);
    bus(1'b0, fwpl_pkg::OFS_STATUS, 32'h0);
    chk("status", {24'h00_0000, v & 8'hFC}, rdata & 32'h0000_00FC);
  endtask
  task automatic setsr(input logic [7:0] v);
    cmd(fwpl_pkg::OP_WRITE_ENABLE);
    bus(1'b1, fwpl_pkg::OFS_WDATA, {24'h00_0000, v});
    cmd(fwpl_pkg::OP_WRITE_STATUS);
    sr(v);
  endtask
  task automatic prog(input logic [7:0] op, input logic [23:0] a,
                      input logic p);
    int g0;
    cmd(fwpl_pkg::OP_WRITE_ENABLE);
    bus(1'b1, fwpl_pkg::OFS_ADDR, {8'h00, a});
    g0 = n_grant;
    cmd(op);
    res(p ? 6'h04 : 6'h01, op);
    chk("grant", p ? 32'h0 : 32'h1, n_grant - g0);
    if (!p)
      chk("op_addr", {8'h00, a}, {8'h00, mem_op_addr});
    while (mem_busy !== 1'b0)
      @(posedge hclk);
  endtask
  // ------------
  // scenarios
  // ------------
  task automatic t_reset();
    sr(8'h00);
    res(6'h00, 8'h00);
  endtask
  task automatic t_latch();
    cmd(fwpl_pkg::OP_WRITE_ENABLE);
    cmd(fwpl_pkg::OP_WRITE_DISABLE);
    cmd(fwpl_pkg::OP_PROG);
    res(6'h02, fwpl_pkg::OP_PROG);
    cmd(fwpl_pkg::OP_WRITE_STATUS);
    res(6'h02, fwpl_pkg::OP_WRITE_STATUS);
  endtask
  task automatic t_lock();
    setsr(8'h80);
    wp_lvl <= 1'b0;
    cmd(fwpl_pkg::OP_WRITE_ENABLE);
    bus(1'b1, fwpl_pkg::OFS_WDATA, 32'h0);
    cmd(fwpl_pkg::OP_WRITE_STATUS);
    res(6'h08, fwpl_pkg::OP_WRITE_STATUS);
    sr(8'h80);
    wp_lvl <= 1'b1;
    setsr(8'h00);
    wp_lvl <= 1'b0;
    setsr(8'h3C);
    wp_lvl <= 1'b1;
    setsr(8'h00);
  endtask
  task automatic t_vol();
    cmd(fwpl_pkg::OP_VOL_ENABLE);
    bus(1'b1, fwpl_pkg::OFS_WDATA, 32'h0000_000C);
    cmd(fwpl_pkg::OP_WRITE_STATUS);
    res(6'h01, fwpl_pkg::OP_WRITE_STATUS);
    sr(8'h0C);
    prog(fwpl_pkg::OP_PROG, 24'h07_FFFF, 1'b1);
    setsr(8'h00);
  endtask
  task automatic t_map();
    for (int c = 0; c < 16; c++)
    begin
      setsr({2'b00, 4'(c), 2'b00});
      for (int b = 0; b < 8; b++)
        prog(fwpl_pkg::OP_PROG, 24'(b) << 16, pmask[c][b]);
    end
  endtask
  task automatic t_erase();
    logic [7:0] ops [9] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52,
      8'hD8, 8'hC7, 8'h60};
    // a refused chip erase leaves the last granted kind standing
    logic [2:0] kinds [9] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3,
      3'h3, 3'h3};
    setsr(8'h04);
    for (int i = 0; i < 9; i++)
    begin
      prog(ops[i], 24'h07_0000, 1'b1);
      prog(ops[i], 24'h00_0000, i > 6);
      chk("kind", {29'h0, kinds[i]}, {29'h0, mem_op_kind});
    end
    setsr(8'h00);
    prog(fwpl_pkg::OP_CHIP_ERASE_A, 24'h00_0000, 1'b0);
    chk("kind", 32'h4, {29'h0, mem_op_kind});
  endtask
  task automatic t_quad();
    setsr(8'h40);
    q2_oe <= 1'b1;
    q3_oe <= 1'b1;
    hold_lvl <= 1'b0;
    @(posedge hclk);
    chk("quad", 32'h1, {31'h0, quad_enable});
    chk("pin2", 32'h0, {31'h0, quad_d2_i});
    chk("pin3", 32'h1, {31'h0, quad_d3_i});
    chk("hold", 32'h0, {31'h0, hold_active});
    setsr(8'h00);
    @(posedge hclk);
    chk("pin2", 32'h1, {31'h0, quad_d2_i});
    chk("pin3_drive", 32'h0, {31'h0, d3_o});
    chk("pin3", 32'h0, {31'h0, quad_d3_i});
    chk("hold", 32'h1, {31'h0, hold_active});
    hold_lvl <= 1'b1;
    q2_oe <= 1'b0;
    q3_oe <= 1'b0;
  endtask
  task automatic t_unmap();
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rdata);
    bus(1'b1, fwpl_pkg::OFS_STATUS, 32'h0000_00FC);
    sr(8'h00);
  endtask
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    {q2_o, q2_oe, q3_o, q3_oe} = 4'h2;
    wp_lvl = 1'b1;
    hold_lvl = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_latch();
    t_lock();
    t_vol();
    t_map();
    t_erase();
    t_quad();
    t_unmap();
    complete_run();
  end
endmodule
